//--- hw/ecl_cfg.svh
`ifndef ECL_CFG_SVH
`define ECL_CFG_SVH

// clock and indicator timing
`define ECL_CLK_PERIOD_NS 20
`define ECL_BLINK_HALF_NS 40000000
`define ECL_SLOW_FACTOR 4

// serial rom word addresses
`define ECL_W_CHIP 8'h01
`define ECL_W_MAKER 8'h02
`define ECL_W_SUBSYS 8'h03
`define ECL_W_BASE_LO 8'h04
`define ECL_W_BASE_HI 8'h05
`define ECL_W_LED 8'h06
`define ECL_W_FIRST 8'h01
`define ECL_W_LAST 8'h06

// chip control word fields
`define ECL_B_ROM_OFF 0
`define ECL_B_RATE_TEN 4
`define ECL_B_RATE_HUNDRED 5
`define ECL_B_RATE_GIGABIT 6
`define ECL_B_FORCED 8
`define ECL_B_WAKE 15

// lower base word fields
`define ECL_B_POWER_SAVE 0
`define ECL_BASE_LO_MSB 15
`define ECL_BASE_LO_LSB 8

// indicator mode word field
`define ECL_MODE_MSB 1
`define ECL_MODE_LSB 0

// wishbone register byte addresses
`define ECL_REG_CTRL 8'h00
`define ECL_REG_CHIP 8'h04
`define ECL_REG_IDS 8'h08
`define ECL_REG_BASE 8'h0C
`define ECL_REG_MODE 8'h10

// control and status bits
`define ECL_CTRL_RELOAD 0
`define ECL_STAT_BUSY 0
`define ECL_STAT_DONE 1

// reset values
`define ECL_RST_POWER_SAVE 1'b1
`define ECL_RST_MODE 2'h1

`endif

//--- hw/ecl_pkg.sv
package ecl_pkg;

	typedef enum logic [1:0] {
		ECL_ST_IDLE = 2'h0,
		ECL_ST_FETCH = 2'h1,
		ECL_ST_DONE = 2'h3
	} ecl_state_e;

	typedef enum logic [1:0] {
		ECL_SPD_TEN = 2'h0,
		ECL_SPD_HUNDRED = 2'h1,
		ECL_SPD_GIGABIT = 2'h2
	} ecl_speed_e;

	typedef enum logic [1:0] {
		ECL_MODE_0 = 2'h0,
		ECL_MODE_1 = 2'h1,
		ECL_MODE_2 = 2'h2,
		ECL_MODE_3 = 2'h3
	} ecl_mode_e;

	typedef struct packed {
		logic up;
		ecl_speed_e speed;
		logic full_duplex;
		logic rx_busy;
		logic tx_busy;
	} ecl_link_s;

	// positive logic: 1 means lit
	typedef struct packed {
		logic ten;
		logic hundred;
		logic gigabit;
		logic duplex;
		logic receive;
		logic transmit;
	} ecl_led_s;

	typedef struct packed {
		logic expansion_rom_off;
		logic phy_rate_ten;
		logic phy_rate_hundred;
		logic phy_rate_gigabit;
		logic forced_setup_select;
		logic wake_lan_enable_bit;
		logic wake_lan_polarity;
		logic [15:0] subsys_identifier;
		logic [15:0] subsys_maker_identifier;
		logic [23:0] io_mem_base;
		logic auto_power_saving;
		logic [1:0] indicator_mode_select;
	} ecl_conf_s;

endpackage

//--- hw/ecl_blink.sv
`timescale 1ns/1ps
`include "ecl_cfg.svh"

module ecl_blink #(
	parameter int unsigned HALF_CYC = 2000000
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	output logic phase
);

	typedef struct packed {
		logic [31:0] cnt;
		logic phase;
	} ecl_blink_s;

	ecl_blink_s s_q;
	ecl_blink_s s_d;

	always_comb begin
		s_d = s_q;
		if (s_q.cnt == 32'(HALF_CYC - 1)) begin
			s_d.cnt = '0;
			s_d.phase = ~s_q.phase;
		end else begin
			s_d.cnt = s_q.cnt + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign phase = s_q.phase;

endmodule

//--- hw/ecl_led.sv
`timescale 1ns/1ps
`include "ecl_cfg.svh"

module ecl_led (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	input wire ecl_pkg::ecl_link_s link,
	input wire logic blink,
	input wire logic slow_blink,
	output ecl_pkg::ecl_led_s leds_n
);

	ecl_pkg::ecl_led_s s_q;
	ecl_pkg::ecl_led_s s_d;
	ecl_pkg::ecl_led_s lit;
	logic s10;
	logic s100;
	logic s1g;
	logic rx_blk;
	logic tx_blk;

	assign s10 = link.up && link.speed == ecl_pkg::ECL_SPD_TEN;
	assign s100 = link.up && link.speed == ecl_pkg::ECL_SPD_HUNDRED;
	assign s1g = link.up && link.speed == ecl_pkg::ECL_SPD_GIGABIT;
	// lit while up, dark during the off half of the blink when busy
	assign rx_blk = link.up && !(link.rx_busy && blink);
	assign tx_blk = link.up && !(link.tx_busy && blink);

	always_comb begin
		lit = '0;
		lit.duplex = link.up && link.full_duplex;
		case (ecl_pkg::ecl_mode_e'(mode))
			ecl_pkg::ECL_MODE_0: begin
				lit.ten = s10 || s1g;
				lit.hundred = s100 || s1g;
				lit.gigabit = link.up;
				lit.receive = rx_blk;
				lit.transmit = tx_blk;
			end
			ecl_pkg::ECL_MODE_1: begin
				lit.ten = s10;
				lit.hundred = s100;
				lit.gigabit = s1g;
				lit.receive = link.rx_busy;
				lit.transmit = link.tx_busy;
			end
			ecl_pkg::ECL_MODE_2: begin
				lit.ten = s100 && slow_blink;
				lit.hundred = s100;
				lit.gigabit = s1g;
				lit.receive = rx_blk;
				lit.transmit = tx_blk;
			end
			ecl_pkg::ECL_MODE_3: begin
				// bi-colour pair: gigabit on ten, hundred on hundred
				lit.ten = s1g;
				lit.hundred = s100;
				lit.gigabit = link.up;
				lit.receive = rx_blk;
				lit.transmit = tx_blk;
			end
			default: begin
				lit = '0;
			end
		endcase
		s_d = ~lit;
	end

	// reset leaves every indicator dark
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign leds_n = s_q;

endmodule

//--- hw/ecl_top.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ecl_cfg.svh"

module ecl_top #(
	parameter int unsigned BLINK_CYC =
		`ECL_BLINK_HALF_NS / `ECL_CLK_PERIOD_NS,
	parameter int unsigned SLOW_CYC = BLINK_CYC * `ECL_SLOW_FACTOR
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	// wishbone classic slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// word fetch toward the serial rom controller
	output logic rom_req,
	output logic [7:0] rom_addr,
	input wire logic rom_valid,
	input wire logic [15:0] rom_data,
	// link state from the phy
	input wire ecl_pkg::ecl_link_s link,
	// loaded configuration
	output ecl_pkg::ecl_conf_s conf,
	output logic load_done,
	// indicator pins
	output logic ten_link_indicator_n,
	output logic hundred_link_indicator_n,
	output logic gigabit_link_indicator_n,
	output logic duplex_indicator_n,
	output logic receive_indicator_n,
	output logic transmit_indicator_n
);

	typedef struct packed {
		ecl_pkg::ecl_state_e st;
		logic [7:0] addr;
		logic rom_req;
		logic done;
		ecl_pkg::ecl_conf_s conf;
		logic [15:0] chip_word;
		logic ack;
		logic [31:0] rdat;
	} ecl_top_s;

	ecl_top_s s_q;
	ecl_top_s s_d;
	logic bus_req;
	logic reload;
	logic blink;
	logic slow_blink;
	ecl_pkg::ecl_led_s leds_n;

	assign bus_req = wb_cyc && wb_stb && !s_q.ack;
	// reload is taken from lane 0 only; other lanes hold nothing writable
	assign reload = bus_req && wb_we && wb_sel[0] &&
		wb_adr == `ECL_REG_CTRL && wb_dat_w[`ECL_CTRL_RELOAD];

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;

		// register bus: one ack per request, unmapped reads return zero
		if (bus_req) begin
			s_d.ack = 1'b1;
			s_d.rdat = '0;
			case (wb_adr)
				`ECL_REG_CTRL: begin
					s_d.rdat[`ECL_STAT_BUSY] =
						s_q.st == ecl_pkg::ECL_ST_FETCH;
					s_d.rdat[`ECL_STAT_DONE] = s_q.done;
				end
				`ECL_REG_CHIP: begin
					s_d.rdat[15:0] = s_q.chip_word;
				end
				`ECL_REG_IDS: begin
					s_d.rdat = {s_q.conf.subsys_identifier,
						s_q.conf.subsys_maker_identifier};
				end
				`ECL_REG_BASE: begin
					s_d.rdat[31:8] = s_q.conf.io_mem_base;
					s_d.rdat[0] = s_q.conf.auto_power_saving;
				end
				`ECL_REG_MODE: begin
					s_d.rdat[1:0] = s_q.conf.indicator_mode_select;
				end
				default: begin
					s_d.rdat = '0;
				end
			endcase
		end

		case (s_q.st)
			ecl_pkg::ECL_ST_IDLE: begin
				// leave idle right after reset to start the load
				s_d.st = ecl_pkg::ECL_ST_FETCH;
				s_d.addr = `ECL_W_FIRST;
				s_d.rom_req = 1'b1;
				s_d.done = 1'b0;
			end
			ecl_pkg::ECL_ST_FETCH: begin
				if (rom_valid) begin
					case (s_q.addr)
						`ECL_W_CHIP: begin
							// reserved bits 1-3, 7, 9-14 kept only in chip_word, not decoded into conf
							s_d.chip_word = rom_data;
							s_d.conf.expansion_rom_off =
								rom_data[`ECL_B_ROM_OFF];
							s_d.conf.phy_rate_ten =
								rom_data[`ECL_B_RATE_TEN];
							s_d.conf.phy_rate_hundred =
								rom_data[`ECL_B_RATE_HUNDRED];
							s_d.conf.phy_rate_gigabit =
								rom_data[`ECL_B_RATE_GIGABIT];
							s_d.conf.forced_setup_select =
								rom_data[`ECL_B_FORCED];
							s_d.conf.wake_lan_enable_bit =
								rom_data[`ECL_B_WAKE];
							s_d.conf.wake_lan_polarity =
								rom_data[`ECL_B_WAKE];
						end
						`ECL_W_MAKER: begin
							s_d.conf.subsys_maker_identifier =
								rom_data;
						end
						`ECL_W_SUBSYS: begin
							s_d.conf.subsys_identifier = rom_data;
						end
						`ECL_W_BASE_LO: begin
							s_d.conf.auto_power_saving =
								rom_data[`ECL_B_POWER_SAVE];
							// outside forced mode the host assigns the base
							if (s_q.conf.forced_setup_select) begin
								s_d.conf.io_mem_base[7:0] = rom_data[
									`ECL_BASE_LO_MSB:`ECL_BASE_LO_LSB];
							end
						end
						`ECL_W_BASE_HI: begin
							if (s_q.conf.forced_setup_select) begin
								s_d.conf.io_mem_base[23:8] =
									rom_data;
							end
						end
						`ECL_W_LED: begin
							s_d.conf.indicator_mode_select = rom_data[
								`ECL_MODE_MSB:`ECL_MODE_LSB];
						end
						default: begin
							s_d.chip_word = s_q.chip_word;
						end
					endcase
					if (s_q.addr == `ECL_W_LAST) begin
						s_d.st = ecl_pkg::ECL_ST_DONE;
						s_d.rom_req = 1'b0;
						s_d.done = 1'b1;
					end else begin
						s_d.addr = s_q.addr + 8'h01;
					end
				end
			end
			ecl_pkg::ECL_ST_DONE: begin
				// a reload mid-fetch is ignored; it is honoured only here
				if (reload) begin
					s_d.st = ecl_pkg::ECL_ST_FETCH;
					s_d.addr = `ECL_W_FIRST;
					s_d.rom_req = 1'b1;
					s_d.done = 1'b0;
					s_d.conf.io_mem_base = '0;
				end
			end
			default: begin
				s_d.st = ecl_pkg::ECL_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.conf.auto_power_saving <= `ECL_RST_POWER_SAVE;
			s_q.conf.indicator_mode_select <= `ECL_RST_MODE;
		end else begin
			s_q <= s_d;
		end
	end

	ecl_blink #(
		.HALF_CYC(BLINK_CYC)
	) u_blink (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.phase(blink)
	);

	ecl_blink #(
		.HALF_CYC(SLOW_CYC)
	) u_slow_blink (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.phase(slow_blink)
	);

	ecl_led u_led (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mode(s_q.conf.indicator_mode_select),
		.link(link),
		.blink(blink),
		.slow_blink(slow_blink),
		.leds_n(leds_n)
	);

	assign wb_ack = s_q.ack;
	assign wb_dat_r = s_q.rdat;
	assign rom_req = s_q.rom_req;
	assign rom_addr = s_q.addr;
	assign conf = s_q.conf;
	assign load_done = s_q.done;
	assign ten_link_indicator_n = leds_n.ten;
	assign hundred_link_indicator_n = leds_n.hundred;
	assign gigabit_link_indicator_n = leds_n.gigabit;
	assign duplex_indicator_n = leds_n.duplex;
	assign receive_indicator_n = leds_n.receive;
	assign transmit_indicator_n = leds_n.transmit;

endmodule

//--- tb/ecl_rom_model.sv
`timescale 1ns/1ps

module ecl_rom_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic rom_req,
	input wire logic [7:0] rom_addr,
	input wire logic [5:0][15:0] words,
	input wire logic [1:0] dly,
	output logic rom_valid,
	output logic [15:0] rom_data
);
	logic [1:0] cnt_q;

	// data is inverted outside valid so a stale word never looks right
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			rom_valid <= 1'b0;
			rom_data <= 16'h0;
		end else begin
			rom_valid <= 1'b0;
			rom_data <= ~rom_data;
			if (rom_req && !rom_valid && cnt_q == dly) begin
				rom_valid <= 1'b1;
				rom_data <= words[rom_addr[2:0] - 3'h1];
				cnt_q <= 2'h0;
			end else if (rom_req && !rom_valid) begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule

//--- tb/ecl_top_props.sv
`timescale 1ns/1ps

module ecl_top_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic rom_req,
	input wire logic [7:0] rom_addr,
	input wire logic rom_valid,
	input wire logic [15:0] rom_data,
	input wire ecl_pkg::ecl_link_s link,
	input wire ecl_pkg::ecl_conf_s conf,
	input wire logic load_done,
	input wire logic ten_link_indicator_n,
	input wire logic gigabit_link_indicator_n,
	input wire logic duplex_indicator_n,
	input wire logic receive_indicator_n
);
	wire logic tk = rom_req && rom_valid;
	wire logic [1:0] md = conf.indicator_mode_select;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	fetch_step_a: assert property (tk && rom_addr != 8'h06 |=>
		rom_req && rom_addr == $past(rom_addr) + 8'h01) else $error("step");
	fetch_end_a: assert property (tk && rom_addr == 8'h06 |=>
		!rom_req && load_done) else $error("end");
	chip_word_a: assert property (tk && rom_addr == 8'h01 |=>
		{conf.expansion_rom_off, conf.phy_rate_ten, conf.phy_rate_hundred,
		conf.phy_rate_gigabit, conf.forced_setup_select,
		conf.wake_lan_enable_bit, conf.wake_lan_polarity} ==
		$past({rom_data[0], rom_data[4], rom_data[5], rom_data[6],
		rom_data[8], rom_data[15], rom_data[15]})) else $error("chip word");
	maker_id_a: assert property (tk && rom_addr == 8'h02 |=>
		conf.subsys_maker_identifier == $past(rom_data)) else $error("maker");
	sub_id_a: assert property (tk && rom_addr == 8'h03 |=>
		conf.subsys_identifier == $past(rom_data)) else $error("subsys");
	base_lo_a: assert property (tk && rom_addr == 8'h04 &&
		conf.forced_setup_select |=>
		conf.io_mem_base[7:0] == $past(rom_data[15:8])) else $error("lo");
	base_hi_a: assert property (tk && rom_addr == 8'h05 &&
		conf.forced_setup_select |=>
		conf.io_mem_base[23:8] == $past(rom_data)) else $error("hi");
	mode_load_a: assert property (tk && rom_addr == 8'h06 |=>
		md == $past(rom_data[1:0])) else $error("mode");
	gig_any_a: assert property (md == 2'h0 && link.up |=>
		!gigabit_link_indicator_n) else $error("gig");
	duplex_a: assert property (!md[1] && link.up |=>
		duplex_indicator_n == !$past(link.full_duplex)) else $error("dup");
	ten_mode1_a: assert property (md == 2'h1 |=>
		ten_link_indicator_n == !$past(link.up && link.speed ==
		ecl_pkg::ECL_SPD_TEN)) else $error("ten");
	rx_mode1_a: assert property (md == 2'h1 && link.up |=>
		receive_indicator_n == !$past(link.rx_busy)) else $error("rx");

	cover property (tk && rom_addr == 8'h06);
	cover property (md == 2'h0 && link.up);
	cover property (md == 2'h2 && link.up);
endmodule

//--- tb/tb_ecl_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("[ERR] %s exp %h got %h", n, e, g); \
	end \
end

module tb_ecl_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r, q;
	logic wb_ack, rom_req, rom_valid, load_done;
	logic [7:0] rom_addr;
	logic [15:0] rom_data;
	logic [1:0] dly = 2'h0;
	logic [5:0][15:0] words;
	logic [5:0] pins_n;
	ecl_pkg::ecl_link_s link = '0;
	ecl_pkg::ecl_conf_s conf;
	logic [7:0] ra [4] = '{8'h08, 8'h0C, 8'h20, 8'h00};
	logic [31:0] re [4] = '{32'h3C4D1A2B, 32'h6F705E00, 32'h0, 32'h2};
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;

	ecl_top #(.BLINK_CYC(8), .SLOW_CYC(32)) ecl_top_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.rom_req(rom_req), .rom_addr(rom_addr), .rom_valid(rom_valid),
		.rom_data(rom_data), .link(link), .conf(conf),
		.load_done(load_done), .ten_link_indicator_n(pins_n[5]),
		.hundred_link_indicator_n(pins_n[4]),
		.gigabit_link_indicator_n(pins_n[3]),
		.duplex_indicator_n(pins_n[2]), .receive_indicator_n(pins_n[1]),
		.transmit_indicator_n(pins_n[0]));

	ecl_rom_model ecl_rom_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.rom_req(rom_req), .rom_addr(rom_addr), .words(words), .dly(dly),
		.rom_valid(rom_valid), .rom_data(rom_data));

	function automatic logic [5:0][15:0] mk(input logic [1:0] m);
		// reserved chip word bits are programmed as zero
		mk[0] = m[0] ? 16'h0020 : 16'h8151;
		mk[1] = 16'h1A2B + {14'h0, m};
		mk[2] = 16'h3C4D - {14'h0, m};
		mk[3] = m[0] ? 16'hAB01 : 16'h5E00;
		mk[4] = 16'h6F70;
		mk[5] = {14'h0, m};
	endfunction

	function automatic ecl_pkg::ecl_conf_s ex(input logic [5:0][15:0] w);
		logic f;
		f = w[0][8];
		ex = {w[0][0], w[0][4], w[0][5], w[0][6], f, w[0][15], w[0][15],
			w[2], w[1], f ? {w[4], w[3][15:8]} : 24'h0, w[3][0], w[5][1:0]};
	endfunction

	task automatic conclude();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= d;
		@(posedge ref_clk);
		while (wb_ack !== 1'b1)
			@(posedge ref_clk);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic pin(input logic [5:0] l, input logic [5:0] lit);
		link <= l;
		@(posedge ref_clk);
		@(posedge ref_clk);
		`CHK("pins", ~lit, pins_n)
	endtask

	// counts lit samples of one pin over 64 cycles; blinking gives half
	task automatic count_lit(input logic [5:0] l, input int b);
		int n;
		n = 0;
		link <= l;
		repeat (2) @(posedge ref_clk);
		repeat (64) begin
			@(posedge ref_clk);
			if (!pins_n[b])
				n++;
		end
		q = n;
	endtask

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		words = mk(2'h0);
		repeat (8) @(posedge ref_clk);
		`CHK("dark", 6'h3F, pins_n)
		`CHK("mode", 2'h1, conf.indicator_mode_select)
		rst_n <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			words <= mk(m[1:0]);
			dly <= m[1:0];
			if (m != 0)
				wb(1'b1, 8'h00, 32'h1);
			while (load_done !== 1'b1)
				@(posedge ref_clk);
			`CHK("conf", ex(mk(m[1:0])), conf)
			if (m == 0) begin
				for (int i = 0; i < 4; i++) begin
					wb(1'b0, ra[i], 32'h0);
					`CHK("reg", re[i], q)
				end
				for (int s = 0; s < 3; s++)
					pin({1'b1, s[1:0], 3'h4}, {s != 1, s != 0, 4'hF});
				pin(6'h04, 6'h00);
				count_lit(6'h22, 1);
				`CHK("rx blink", 32'd32, q)
			end
			if (m == 1) begin
				for (int s = 0; s < 3; s++)
					pin({1'b1, s[1:0], 3'h2}, {s == 0, s == 1, s == 2, 3'h2});
				pin(6'h21, 6'h21);
			end
			if (m == 2) begin
				link <= 6'h20;
				@(posedge ref_clk);
				@(posedge ref_clk);
				`CHK("ten", 1'b1, pins_n[5])
				count_lit(6'h28, 5);
				`CHK("ten slow", 32'd32, q)
			end
			if (m == 3)
				pin({1'b1, 2'h2, 3'h4}, 6'h2F);
		end
		// hardware reset in mid-run must restart the whole load
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK("rst done", 1'b0, load_done)
		`CHK("rst dark", 6'h3F, pins_n)
		`CHK("rst mode", 2'h1, conf.indicator_mode_select)
		rst_n <= 1'b1;
		while (load_done !== 1'b1)
			@(posedge ref_clk);
		`CHK("rst conf", ex(mk(2'h3)), conf)
		conclude();
	end
endmodule

bind ecl_top ecl_top_props ecl_top_props_i (.ref_clk(ref_clk),
	.rst_n(rst_n), .rom_req(rom_req), .rom_addr(rom_addr),
	.rom_valid(rom_valid), .rom_data(rom_data), .link(link), .conf(conf),
	.load_done(load_done), .ten_link_indicator_n(ten_link_indicator_n),
	.gigabit_link_indicator_n(gigabit_link_indicator_n),
	.duplex_indicator_n(duplex_indicator_n),
	.receive_indicator_n(receive_indicator_n));
